// ===== rtl/seec_pkg.sv
// constants and types for the serial eeprom bus controller (host end)
// assumes one 200 MHz clock; the eeprom sits on scl/sda behind a pull-up
//
// Contract
// - two word address bytes follow write address
// - byte write: data acked, controller then stops
// - page write: more data bytes, ended by stop
// - busy device nacks; controller polls until ack
// - ident write: type 1011b, select bit zero
// - lock command: type 1011b, select one, data bit1
// - reads use direction bit one
// - single read: controller nacks then stops
// - random read: dummy write, restart, read address
// - controller ack continues read; nack ends
// - ident read: select bit zero, stay inside page
// - address byte: type code, straps, direction
package seec_pkg;
  localparam int CLK_NS = 5;
  // a quarter of one 400 kHz scl bit
  localparam int T_QTR_NS = 625;
  localparam int QTR_CYC = (T_QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WR_MS = 5;
  localparam int WR_CYC = T_WR_MS * 1000000 / CLK_NS;
  localparam logic [3:0] TYPE_MEM = 4'ha;
  localparam logic [3:0] TYPE_ID = 4'hb;
  localparam int IDSEL_BIT = 10;
  localparam int LOCK_BIT = 1;
  localparam logic [7:0] LOCK_DATA = 8'h02;
  localparam logic [7:0] STATUS_DATA = 8'h00;
  localparam int PAGE_BYTES = 64;
  localparam int ADDR_W = 14;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [2:0] {
    OP_WRITE, OP_READ_CUR, OP_READ_RAND, OP_ID_WRITE,
    OP_ID_READ, OP_LOCK, OP_LOCK_STATUS
  } seec_op_t;
  typedef enum logic [2:0] {
    S_IDLE, S_START, S_BIT, S_LOAD, S_STOP, S_DONE
  } seec_state_t;
  typedef enum logic [2:0] {
    ST_DEVW, ST_AH, ST_AL, ST_WD, ST_DEVR, ST_RD, ST_ABORT
  } seec_stage_t;
endpackage

// ===== rtl/seec_ctrl.sv
// host controller that runs eeprom transfers over scl and open-drain sda
// assumes sda is pulled up outside and the command side shares the clock
`timescale 1ns/100ps

// write data buffer; depth must be a power of two
module seec_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp, rp, next_wp, next_rp;
  assign in_ready = (wp - rp) != (AW+1)'(D);
  assign out_valid = wp != rp;
  assign out_data = mem[rp[AW-1:0]];
  // pointers carry one extra bit so full and empty differ
  always_comb begin
    next_wp = wp + ((in_valid && in_ready) ? 1'b1 : 1'b0);
    next_rp = rp + ((out_valid && out_ready) ? 1'b1 : 1'b0);
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
  end
  always_ff @(posedge clock) begin
    if (in_valid && in_ready) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end
endmodule

module seec_ctrl import seec_pkg::*; #(
  parameter int LEN_W = 8,
  parameter int WR_LIMIT = WR_CYC,
  // clocks per scl quarter; a smaller count gives a faster bus
  parameter int QTR = QTR_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire seec_op_t cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [LEN_W-1:0] cmd_len,
  input wire logic [2:0] cmd_strap,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic fail,
  output logic busy,
  output logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  localparam int TW = $clog2(WR_LIMIT + 1);
  seec_state_t state, next_state;
  seec_stage_t stage, next_stage;
  seec_op_t op, next_op;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [2:0] strap, next_strap;
  logic [LEN_W-1:0] cnt, next_cnt;
  logic [7:0] sh, next_sh, next_rd_data, id_room;
  logic [3:0] bitn, next_bit;
  logic [1:0] qtr, next_qtr;
  logic [7:0] div, next_div;
  logic [TW-1:0] tcnt, next_tcnt;
  logic next_scl, drv, next_drv, nack_seen, next_nack_seen;
  logic poll, next_poll, next_fail, next_rd_valid;
  logic sda_m, sda_s, qtick, byte_end, f_valid, f_pop;
  logic [7:0] f_data;
  logic [3:0] op_type;

  seec_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clock(clock), .rst_n(rst_n),
    .in_valid(wr_valid), .in_ready(wr_ready), .in_data(wr_data),
    .out_valid(f_valid), .out_ready(f_pop), .out_data(f_data)
  );

  assign cmd_ready = state == S_IDLE;
  assign busy = state != S_IDLE;
  assign done = state == S_DONE;
  assign sda_out = 1'b0;
  assign sda_oe = drv;
  assign qtick = div == 8'(QTR - 1);
  assign byte_end = qtick && state == S_BIT && qtr == 2'd3 && bitn == 4'd8;
  assign op_type = (op == OP_WRITE || op == OP_READ_CUR ||
                    op == OP_READ_RAND) ? TYPE_MEM : TYPE_ID;
  assign id_room = 8'(PAGE_BYTES) - {2'b00, cmd_addr[5:0]};

  // sequencer and bit engine; each qtick steps one quarter of a bit
  always_comb begin
    next_state = state;
    next_stage = stage;
    next_op = op;
    next_addr = addr;
    next_strap = strap;
    next_cnt = cnt;
    next_sh = sh;
    next_bit = bitn;
    next_qtr = qtr;
    next_scl = scl;
    next_drv = drv;
    next_nack_seen = nack_seen;
    next_poll = poll;
    next_fail = fail;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    next_div = qtick ? 8'h00 : div + 8'h01;
    // write cycle timer runs only while polling
    next_tcnt = poll ? tcnt + 1'b1 : '0;
    f_pop = 1'b0;
    case (state)
      S_IDLE: if (cmd_valid) begin
        next_op = cmd_op;
        next_strap = cmd_strap;
        next_addr = cmd_addr;
        if (cmd_op == OP_LOCK) begin
          next_addr[IDSEL_BIT] = 1'b1;
        end else if (cmd_op >= OP_ID_WRITE) begin
          next_addr[IDSEL_BIT] = 1'b0;
        end
        next_cnt = (cmd_len == '0) ? LEN_W'(1) : cmd_len;
        if (cmd_op == OP_ID_READ && cmd_len > LEN_W'(id_room)) begin
          next_cnt = LEN_W'(id_room);
        end
        if (cmd_op == OP_LOCK || cmd_op == OP_LOCK_STATUS) begin
          next_cnt = LEN_W'(1);
        end
        // current read relies on the device's own address counter
        next_stage = (cmd_op == OP_READ_CUR) ? ST_DEVR : ST_DEVW;
        next_poll = 1'b0;
        next_fail = 1'b0;
        next_qtr = 2'd0;
        next_state = S_START;
      end
      S_START: if (qtick) begin
        next_qtr = qtr + 2'd1;
        case (qtr)
          2'd0: begin
            next_scl = 1'b0;
            next_drv = 1'b0;
          end
          2'd1: next_scl = 1'b1;
          2'd2: next_drv = 1'b1;
          default: begin
            next_scl = 1'b0;
            next_bit = 4'd0;
            if (stage == ST_ABORT) begin
              next_state = S_STOP;
            end else begin
              next_sh = {op_type, strap, stage == ST_DEVR};
              next_state = S_BIT;
            end
          end
        endcase
      end
      S_BIT: if (qtick) begin
        next_qtr = qtr + 2'd1;
        case (qtr)
          2'd0: begin
            next_scl = 1'b0;
            if (bitn == 4'd8) begin
              // ninth clock: we ack read bytes except the last
              next_drv = stage == ST_RD && cnt != LEN_W'(1);
            end else begin
              next_drv = stage != ST_RD && !sh[7];
            end
          end
          2'd1: next_scl = 1'b1;
          2'd2: if (bitn == 4'd8) begin
            next_nack_seen = sda_s;
          end else begin
            next_sh = {sh[6:0], sda_s};
          end
          default: begin
            next_scl = 1'b0;
            if (bitn != 4'd8) begin
              next_bit = bitn + 4'd1;
            end else begin
              next_bit = 4'd0;
              next_drv = 1'b0;
              case (stage)
                ST_DEVW: if (nack_seen) begin
                  next_fail = !poll;
                  next_state = S_STOP;
                end else if (poll) begin
                  next_poll = 1'b0;
                  next_state = S_STOP;
                end else begin
                  next_stage = ST_AH;
                  next_sh = {2'b00, addr[13:8]};
                end
                ST_AH: if (nack_seen) begin
                  next_fail = 1'b1;
                  next_state = S_STOP;
                end else begin
                  next_stage = ST_AL;
                  next_sh = addr[7:0];
                end
                ST_AL: if (nack_seen) begin
                  next_fail = 1'b1;
                  next_state = S_STOP;
                end else if (op == OP_READ_RAND || op == OP_ID_READ) begin
                  next_stage = ST_DEVR;
                  next_state = S_START;
                end else begin
                  next_stage = ST_WD;
                  next_state = S_LOAD;
                end
                ST_WD: if (nack_seen) begin
                  // locked ident page refuses data, no write cycle
                  next_fail = 1'b1;
                  next_state = S_STOP;
                end else if (cnt == LEN_W'(1)) begin
                  if (op == OP_LOCK_STATUS) begin
                    // restart instead of stop so nothing is programmed
                    next_stage = ST_ABORT;
                    next_state = S_START;
                  end else begin
                    next_poll = 1'b1;
                    next_state = S_STOP;
                  end
                end else begin
                  next_cnt = cnt - LEN_W'(1);
                  next_state = S_LOAD;
                end
                ST_DEVR: if (nack_seen) begin
                  next_fail = 1'b1;
                  next_state = S_STOP;
                end else begin
                  next_stage = ST_RD;
                end
                ST_RD: begin
                  next_rd_valid = 1'b1;
                  next_rd_data = sh;
                  if (cnt == LEN_W'(1)) begin
                    next_state = S_STOP;
                  end else begin
                    next_cnt = cnt - LEN_W'(1);
                  end
                end
                default: next_state = S_STOP;
              endcase
            end
          end
        endcase
      end
      // scl is held low here, so an empty buffer just stretches the bit
      S_LOAD: if (op == OP_LOCK) begin
        next_sh = LOCK_DATA;
        next_state = S_BIT;
      end else if (op == OP_LOCK_STATUS) begin
        next_sh = STATUS_DATA;
        next_state = S_BIT;
      end else if (f_valid) begin
        f_pop = 1'b1;
        next_sh = f_data;
        next_state = S_BIT;
      end
      S_STOP: if (qtick) begin
        next_qtr = qtr + 2'd1;
        case (qtr)
          2'd0: begin
            next_scl = 1'b0;
            next_drv = 1'b1;
          end
          2'd1: next_scl = 1'b1;
          2'd2: next_drv = 1'b0;
          default: if (poll && tcnt < TW'(WR_LIMIT)) begin
            next_stage = ST_DEVW;
            next_state = S_START;
          end else begin
            next_fail = fail || poll;
            next_poll = 1'b0;
            next_state = S_DONE;
          end
        endcase
      end
      S_DONE: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // registers only; sda passes two flops before the engine sees it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      stage <= ST_DEVW;
      op <= OP_WRITE;
      addr <= '0;
      strap <= 3'h0;
      cnt <= '0;
      sh <= 8'h00;
      bitn <= 4'h0;
      qtr <= 2'h0;
      div <= 8'h00;
      tcnt <= '0;
      scl <= 1'b1;
      drv <= 1'b0;
      nack_seen <= 1'b1;
      poll <= 1'b0;
      fail <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      state <= next_state;
      stage <= next_stage;
      op <= next_op;
      addr <= next_addr;
      strap <= next_strap;
      cnt <= next_cnt;
      sh <= next_sh;
      bitn <= next_bit;
      qtr <= next_qtr;
      div <= next_div;
      tcnt <= next_tcnt;
      scl <= next_scl;
      drv <= next_drv;
      nack_seen <= next_nack_seen;
      poll <= next_poll;
      fail <= next_fail;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      sda_m <= sda_in;
      sda_s <= sda_m;
    end
  end

  a_ack_release: assert property (@(posedge clock) disable iff (!rst_n)
    (state == S_BIT && bitn == 4'd8 && stage != ST_RD && qtr != 2'd0)
    |-> !sda_oe) else $error("sda driven in device ack slot");
  a_addr_follow: assert property (@(posedge clock) disable iff (!rst_n)
    (byte_end && stage == ST_DEVW && !nack_seen && !poll)
    |=> (stage == ST_AH && sh == {2'b00, addr[13:8]}))
    else $error("high address byte did not follow");
  a_last_stop: assert property (@(posedge clock) disable iff (!rst_n)
    (byte_end && stage == ST_WD && !nack_seen && cnt == LEN_W'(1) &&
     op != OP_LOCK_STATUS) |=> (state == S_STOP && poll))
    else $error("last write byte not ended by stop");
  a_poll_retry: assert property (@(posedge clock) disable iff (!rst_n)
    (state == S_STOP && qtick && qtr == 2'd3 && poll &&
     tcnt < TW'(WR_LIMIT)) |=> (state == S_START && stage == ST_DEVW))
    else $error("poll did not restart");
  a_id_select: assert property (@(posedge clock) disable iff (!rst_n)
    (stage == ST_AH && (op == OP_ID_WRITE || op == OP_ID_READ ||
     op == OP_LOCK_STATUS)) |-> !addr[IDSEL_BIT])
    else $error("ident select bit set");
  a_lock_data: assert property (@(posedge clock) disable iff (!rst_n)
    (state == S_BIT && stage == ST_WD && op == OP_LOCK && bitn == 4'd0 &&
     qtr == 2'd0) |-> (sh[LOCK_BIT] && addr[IDSEL_BIT]))
    else $error("lock command malformed");
  a_read_dir: assert property (@(posedge clock) disable iff (!rst_n)
    (state == S_BIT && stage == ST_DEVR && bitn == 4'd0 && qtr == 2'd0)
    |-> sh[0]) else $error("read address without read direction");
  a_read_nack: assert property (@(posedge clock) disable iff (!rst_n)
    (state == S_BIT && stage == ST_RD && bitn == 4'd8 && qtr != 2'd0)
    |-> (sda_oe == (cnt != LEN_W'(1))))
    else $error("wrong ack on read byte");
  a_rand_restart: assert property (@(posedge clock) disable iff (!rst_n)
    (byte_end && stage == ST_AL && !nack_seen && op == OP_READ_RAND)
    |=> (state == S_START && stage == ST_DEVR))
    else $error("random read missing restart");
  a_dev_byte: assert property (@(posedge clock) disable iff (!rst_n)
    (state == S_BIT && (stage == ST_DEVW || stage == ST_DEVR) &&
     bitn == 4'd0 && qtr == 2'd0) |-> (sh[7:1] == {op_type, strap}))
    else $error("device address byte malformed");
endmodule

// ===== test/seec_eeprom_model.sv
// behavioural two-wire eeprom on the far side of the controller
// assumes sda is a pulled-up wire that it pulls low through drive_low
`timescale 1ns/100ps
module seec_eeprom_model #(
  parameter int WR_NS = 20000
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic [2:0] strap,
  input wire logic write_inhibit_pin,
  output logic drive_low
);
  logic [7:0] mem [0:16383];
  logic [7:0] idm [0:63];
  logic [7:0] sh, rb;
  logic [13:0] addr;
  logic [3:0] cnt;
  // phase: 0 dev, 1 high addr, 2 low addr, 3 write data, 4 read, 5 deaf
  logic [2:0] ph;
  logic ident, busy, locked, lock_req;
  logic [13:0] pa [$];
  logic [7:0] pd [$];
  // blank array so unwritten bytes read back as all ones
  initial begin
    for (int i = 0; i < 16384; i++) mem[i] = 8'hff;
    for (int i = 0; i < 64; i++) idm[i] = 8'hff;
    {drive_low, busy, locked, lock_req, ident} = 5'h00;
    {ph, cnt, addr} = {3'd5, 4'h0, 14'h0000};
  end
  // start: a part still programming ignores the whole transfer
  always @(negedge sda) if (scl === 1'b1) begin
    cnt = 0;
    pa.delete();
    pd.delete();
    lock_req = 0;
    ph = busy ? 3'd5 : 3'd0;
  end
  // stop after write data commits it and starts the write cycle, except array data while write_inhibit_pin is high
  always @(posedge sda) if (scl === 1'b1) begin
    if (ph == 3'd3 && (pd.size() > 0 || lock_req)) begin
      if (lock_req) locked = 1;
      else if (!write_inhibit_pin || ident) begin
        foreach (pd[k]) begin
          if (ident) idm[pa[k][5:0]] = pd[k];
          else mem[pa[k]] = pd[k];
        end
      end
      busy = !(write_inhibit_pin && !ident && !lock_req);
    end
    ph = 3'd5;
    drive_low = 0;
  end
  // self-timed cycle ends on its own
  always @(posedge busy) busy <= #(WR_NS) 1'b0;
  // sample on rising scl; a high ninth bit in a read ends it
  always @(posedge scl) if (ph != 3'd5) begin
    cnt = cnt + 4'd1;
    if (cnt <= 4'd8) sh = {sh[6:0], sda};
    if (cnt == 4'd9 && ph == 3'd4 && sda === 1'b1) ph = 3'd5;
  end
  // change sda only while scl is low
  always @(negedge scl) begin
    if (ph == 3'd5) drive_low = 0;
    else if (cnt == 4'd8) begin
      if (ph == 3'd4) drive_low = 0;
      else if (ph == 3'd0) begin
        ident = (sh[7:4] == 4'hb);
        if ((sh[7:4] == 4'ha || ident) && sh[3:1] == strap) begin
          drive_low = 1;
          ph = sh[0] ? 3'd4 : 3'd1;
        end else ph = 3'd5;
      end else if (ph == 3'd1) begin
        addr[13:8] = sh[5:0];
        drive_low = 1;
        ph = 3'd2;
      end else if (ph == 3'd2) begin
        addr[7:0] = sh;
        drive_low = 1;
        ph = 3'd3;
      end else begin
        drive_low = !(ident && locked);
        if (ident && addr[10]) lock_req = sh[1];
        else if (drive_low) begin
          pa.push_back(addr);
          pd.push_back(sh);
        end
        addr[5:0] = addr[5:0] + 6'd1;
      end
    end else if (cnt == 4'd9) begin
      cnt = 0;
      drive_low = 0;
      if (ph == 3'd4) begin
        rb = ident ? idm[addr[5:0]] : mem[addr];
        addr = addr + 14'd1;
        drive_low = !rb[7];
      end
    end else if (ph == 3'd4 && cnt != 0) drive_low = !rb[3'd7 - cnt[2:0]];
  end
endmodule

// ===== test/seec_ctrl_test.sv
// self-checking bench for the eeprom bus controller
// assumes the eeprom model behind a pulled-up sda wire
`timescale 1ns/100ps
module seec_ctrl_test import seec_pkg::*;;
  logic clock = 0;
  logic rst_n = 0;
  logic cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, done, fail;
  logic busy, scl, sda_out, sda_oe, dev_low, fa;
  logic wip = 1'b0;
  seec_op_t cmd_op;
  logic [13:0] cmd_addr;
  logic [7:0] cmd_len, wr_data, rd_data, wb, dev_b;
  logic [2:0] cmd_strap;
  logic [3:0] wc = 4'h8;
  logic [7:0] rq [$];
  int failures = 0, comparisons = 0, cyc = 0, starts = 0;
  // open-drain wire with pull-up
  wire logic sda = !(sda_oe || dev_low);
  seec_ctrl #(.LEN_W(8), .WR_LIMIT(20000), .QTR(8)) DUT (.clock(clock),
    .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .cmd_strap(cmd_strap), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .done(done), .fail(fail), .busy(busy), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe));
  // a short write cycle: the first poll is refused, the second taken
  seec_eeprom_model #(.WR_NS(1000)) M (.scl(scl), .sda(sda),
    .strap(3'h5), .write_inhibit_pin(wip), .drive_low(dev_low));
  initial forever #2.5 clock = ~clock;
  // hang guard; the whole run needs roughly 17000 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      report_and_stop;
    end
  end
  // wire monitor: count starts, keep the first byte after each
  always @(negedge sda) if (scl === 1'b1) begin
    starts++;
    wc = 0;
  end
  always @(posedge scl) if (wc < 8) begin
    wb = {wb[6:0], sda};
    wc++;
    if (wc == 8) dev_b = wb;
  end
  // read bytes are collected where rd_valid has settled
  always @(negedge clock) if (rd_valid === 1'b1) rq.push_back(rd_data);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one command: hold it until taken, then wait for done
  task automatic run(input seec_op_t op, input logic [13:0] a,
    input logic [7:0] n, input logic [2:0] s);
    int k;
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_len <= n;
    cmd_strap <= s;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (cmd_ready !== 1'b1 && k < 10);
    @(posedge clock);
    cmd_valid <= 1'b0;
    @(negedge clock);
    check({busy, cmd_ready, sda_out}, 3'b100);
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (done !== 1'b1 && k < 25000);
    fa = fail;
    check(k < 25000, 1);
    repeat (2) @(posedge clock);
  endtask
  // fill the write buffer until it refuses
  task automatic t_fill;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      wr_valid <= 1'b1;
      wr_data <= (i == 0) ? 8'h5a : (i == 1) ? 8'hc3 : 8'h10;
    end
    @(posedge clock);
    wr_valid <= 1'b0;
    @(negedge clock);
    check(wr_ready, 0);
  endtask
  // two bytes from the last page byte: second one wraps to page start
  task automatic t_write;
    starts = 0;
    run(OP_WRITE, 14'h003f, 8'h02, 3'h5);
    check(fa, 0);
    check(starts, 3);
    check(dev_b, 8'haa);
    check(M.mem[14'h003f], 8'h5a);
    check(M.mem[14'h0000], 8'hc3);
    check(M.mem[14'h0040], 8'hff);
    check(wr_ready, 1);
  endtask
  // random read of two bytes from the wrapped location
  task automatic t_read;
    rq.delete();
    run(OP_READ_RAND, 14'h0000, 8'h02, 3'h5);
    check(fa, 0);
    check(rq.size(), 2);
    check(rq[0], 8'hc3);
    check(rq[1], 8'hff);
    check(dev_b, 8'hab);
    check(M.addr, 14'h0002);
  endtask
  // lock status on an unlocked page: acked, no write cycle
  task automatic t_status;
    run(OP_LOCK_STATUS, 14'h0000, 8'h01, 3'h5);
    check(fa, 0);
    check(dev_b, 8'hba);
    check(M.busy, 0);
  endtask
  // wrong strap bits: address refused, nothing read
  task automatic t_strap;
    rq.delete();
    run(OP_READ_CUR, 14'h0000, 8'h01, 3'h2);
    check(fa, 1);
    check(dev_b, 8'ha5);
    check(rq.size(), 0);
  endtask
  // current read of length zero: one byte from the device counter
  task automatic t_cur;
    rq.delete();
    starts = 0;
    run(OP_READ_CUR, 14'h1234, 8'h00, 3'h5);
    check(fa, 0);
    check(starts, 1);
    check(dev_b, 8'hab);
    check(rq.size(), 1);
    check(rq[0], 8'hff);
    check(M.addr, 14'h0003);
  endtask
  // ident page: two bytes at its end, then a read clamped at the end
  task automatic t_ident;
    starts = 0;
    run(OP_ID_WRITE, 14'h3c3e, 8'h02, 3'h5);
    check(fa, 0);
    check(starts, 3);
    check(dev_b, 8'hba);
    check(M.addr, 14'h3800);
    check(M.idm[6'h3e], 8'h10);
    check(M.idm[6'h3f], 8'h10);
    rq.delete();
    run(OP_ID_READ, 14'h003e, 8'h05, 3'h5);
    check(fa, 0);
    check(rq.size(), 2);
    check({rq[0], rq[1]}, 16'h1010);
    check(dev_b, 8'hbb);
  endtask
  // protect pin high: data acked, array kept, no write cycle
  task automatic t_inhibit;
    starts = 0;
    @(posedge clock);
    wip <= 1'b1;
    run(OP_WRITE, 14'h0100, 8'h01, 3'h5);
    wip <= 1'b0;
    check(fa, 0);
    check(starts, 2);
    check(M.mem[14'h0100], 8'hff);
  endtask
  // lock the ident page; status and page writes are then refused
  task automatic t_lock;
    starts = 0;
    run(OP_LOCK, 14'h0000, 8'h04, 3'h5);
    check(fa, 0);
    check(starts, 3);
    check(M.locked, 1);
    run(OP_LOCK_STATUS, 14'h0000, 8'h01, 3'h5);
    check(fa, 1);
    run(OP_ID_WRITE, 14'h0000, 8'h01, 3'h5);
    check(fa, 1);
    check(M.idm[6'h00], 8'hff);
    check(M.busy, 0);
  endtask
  initial begin
    {cmd_valid, wr_valid, wr_data, cmd_addr} = 0;
    {cmd_len, cmd_strap} = 0;
    cmd_op = OP_WRITE;
    repeat (4) @(posedge clock);
    @(negedge clock);
    check({scl, sda_oe, cmd_ready, busy, done, rd_valid}, 6'h28);
    @(posedge clock);
    rst_n <= 1'b1;
    t_fill;
    t_write;
    t_read;
    t_cur;
    t_status;
    t_strap;
    t_ident;
    t_inhibit;
    t_lock;
    report_and_stop;
  end
endmodule
